// ---- hdl/prsl_regs.sv ----
`timescale 1ns/100ps

module prsl_regs #(
  parameter int DLY0_CYC = prsl_pkg::DLY0_US * prsl_pkg::CLK_MHZ,            // 50 us in cycles.
  parameter int DLY1_CYC = prsl_pkg::DLY1_MS * 1000 * prsl_pkg::CLK_MHZ,     // 50 ms in cycles.
  parameter int DLY2_CYC = prsl_pkg::DLY2_MS * 1000 * prsl_pkg::CLK_MHZ,     // 100 ms in cycles.
  parameter int DLY3_CYC = prsl_pkg::DLY3_MS * 1000 * prsl_pkg::CLK_MHZ      // 200 ms in cycles.
) (
  input  wire logic                  core_clk,           // Core clock, 100 MHz.
  input  wire logic                  sys_rst,            // Synchronous reset, active high.
  input  wire prsl_pkg::prsl_req_type reg_req,           // Register request from the serial port.
  output logic [7:0]                 reg_rdata,          // Read data, registered.
  input  wire logic [7:0]            func_strap,         // Factory defaults for function bits 4..2.
  input  wire logic                  buck1_ok,           // Buck1 output within range.
  input  wire logic                  buck2_ok,           // Buck2 output within range.
  input  wire logic                  supply_low,         // Linear supply below 2.8 V.
  output logic [3:0]                 ramp_step_code,     // Effective ramp rate code.
  output logic                       ramp_instant,       // Target change is immediate.
  output logic                       spread_en,          // Spread modulation active.
  output logic signed [7:0]          freq_offset_khz,    // Switching offset from 2 MHz, kHz.
  output logic                       power_good_reset_n, // Delayed power-good reset, active low.
  output logic                       regulators_en,      // Enable for all four regulators.
  output logic [4:0]                 reg1_voltage_code   // LDO1 voltage code.
);

  logic [7:0] ramp_q, ramp_d;     // Ramp rate register.
  logic [7:0] func_q, func_d;     // Function register.
  logic [7:0] ldo1_q, ldo1_d;     // LDO1 register.
  logic       strap_done_q;       // Strap captured after reset release.

  // Address decode and write strobes.
  wire hit_ramp = reg_req.addr == prsl_pkg::ADDR_RAMP;
  wire hit_func = reg_req.addr == prsl_pkg::ADDR_FUNC;
  wire hit_ldo1 = reg_req.addr == prsl_pkg::ADDR_LDO1;
  wire wr_ramp  = reg_req.wr && hit_ramp;
  wire wr_func  = reg_req.wr && hit_func;
  wire wr_ldo1  = reg_req.wr && hit_ldo1;

  // Next values keep only the writable bits so reserved bits stay zero in the function and LDO1 registers.
  // The ramp register's reserved bits hold their reset pattern, so a write only touches the code.
  assign ramp_d = wr_ramp ? ((reg_req.wdata & prsl_pkg::MASK_RAMP) | (ramp_q & ~prsl_pkg::MASK_RAMP)) : ramp_q;
  assign func_d = wr_func ? (reg_req.wdata & prsl_pkg::MASK_FUNC) : func_q;
  assign ldo1_d = wr_ldo1 ? (reg_req.wdata & prsl_pkg::MASK_LDO1) : ldo1_q;

  // Register storage; the factory strap is loaded by the first clocked step after release unless that step writes the function register, never by reset itself.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ramp_q       <= prsl_pkg::RST_RAMP;
      func_q       <= prsl_pkg::RST_FUNC_LOW;
      ldo1_q       <= prsl_pkg::RST_LDO1;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q && !wr_func) begin
      func_q       <= (func_q & 8'h03) | (func_strap & 8'h1C);
      strap_done_q <= 1'b1;
      ramp_q       <= ramp_d;
      ldo1_q       <= ldo1_d;
    end else begin
      strap_done_q <= 1'b1;
      ramp_q       <= ramp_d;
      func_q       <= func_d;
      ldo1_q       <= ldo1_d;
    end
  end

  // Read data; unmapped addresses read zero.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      reg_rdata <= hit_ramp ? ramp_q : hit_func ? func_q : hit_ldo1 ? ldo1_q : 8'h00;
    end
  end

  // Ramp code: values above ten behave as ten.
  wire [3:0] ramp_raw = ramp_q[3:0];
  assign ramp_step_code = (ramp_raw > prsl_pkg::RAMP_MAX) ? prsl_pkg::RAMP_MAX : ramp_raw;
  assign ramp_instant   = ramp_raw == prsl_pkg::RAMP_INSTANT;

  // LDO1 code passes straight to the regulator; codes above 0x19 are left undefined.
  assign reg1_voltage_code = ldo1_q[4:0];

  // Control fields.
  assign spread_en = func_q[prsl_pkg::FUNC_SPREAD_BIT];
  wire       slow_mod_sel        = func_q[prsl_pkg::FUNC_SLOW_BIT];
  wire [1:0] reset_delay_sel     = func_q[prsl_pkg::FUNC_DELAY_LSB +: 2];
  wire       undervoltage_bypass = func_q[prsl_pkg::FUNC_BYPASS_BIT];

  // Lockout drops every regulator on low supply unless bypassed.
  assign regulators_en = !(supply_low && !undervoltage_bypass);

  // Triangle sweep: one step per divider pulse, equal up and down slopes.
  logic [15:0]           div_q;   // Step divider.
  prsl_pkg::prsl_sweep_type dir_q; // Sweep direction.
  logic signed [7:0]     off_q;   // Current offset in kHz.
  wire [15:0] step_cyc = slow_mod_sel ? 16'(prsl_pkg::SLOW_STEP_CYC) : 16'(prsl_pkg::FAST_STEP_CYC);
  wire        step_en  = div_q >= step_cyc - 16'h0001;
  localparam logic signed [7:0] DEV = 8'(prsl_pkg::DEV_STEPS);

  // The sweep parks at centre while disabled so each enable starts from 2 MHz.
  always_ff @(posedge core_clk) begin
    if (sys_rst || !spread_en) begin
      div_q <= 16'h0000;
      dir_q <= prsl_pkg::SWEEP_UP;
      off_q <= 8'sh00;
    end else if (step_en) begin
      div_q <= 16'h0000;
      case (dir_q)
        prsl_pkg::SWEEP_UP: begin
          off_q <= off_q + 8'sh01;
          if (off_q == DEV - 8'sh01) dir_q <= prsl_pkg::SWEEP_DOWN;
        end
        prsl_pkg::SWEEP_DOWN: begin
          off_q <= off_q - 8'sh01;
          if (off_q == -DEV + 8'sh01) dir_q <= prsl_pkg::SWEEP_UP;
        end
        default: dir_q <= prsl_pkg::SWEEP_UP;
      endcase
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end
  assign freq_offset_khz = off_q;

  // Power-good delay: counts while both bucks are good, restarts on any dip.
  logic [31:0] dly_q;    // Delay counter.
  logic        pgood_q;  // Registered power-good reset release.
  wire  [31:0] dly_lim = (reset_delay_sel == 2'b00) ? 32'(DLY0_CYC) :
                         (reset_delay_sel == 2'b01) ? 32'(DLY1_CYC) :
                         (reset_delay_sel == 2'b10) ? 32'(DLY2_CYC) : 32'(DLY3_CYC);
  wire         bucks_ok = buck1_ok && buck2_ok;

  // A shorter delay chosen mid-count takes effect at once, which is safe: release only moves earlier.
  always_ff @(posedge core_clk) begin
    if (sys_rst || !bucks_ok) begin
      dly_q   <= 32'h00000000;
      pgood_q <= 1'b0;
    end else if (dly_q >= dly_lim - 32'h00000001) begin
      pgood_q <= 1'b1;
    end else begin
      dly_q <= dly_q + 32'h00000001;
    end
  end
  assign power_good_reset_n = pgood_q;

  AST_RAMP_SAT: assert property (@(posedge core_clk) disable iff (sys_rst)
    ramp_q[3:0] > 4'hA |-> ramp_step_code == 4'hA) else $error("ramp code not saturated");
  AST_RSV_ZERO: assert property (@(posedge core_clk) disable iff (sys_rst)
    func_q[7:5] == 3'h0 && ramp_q[7] == 1'b0 && ldo1_q[7:5] == 3'h0) else $error("reserved bit set");
  AST_LOCKOUT: assert property (@(posedge core_clk) disable iff (sys_rst)
    supply_low && !func_q[4] |-> !regulators_en) else $error("lockout missed");
  AST_BYPASS: assert property (@(posedge core_clk) disable iff (sys_rst)
    func_q[4] |-> regulators_en) else $error("bypass ignored");
  AST_SPREAD_OFF: assert property (@(posedge core_clk) disable iff (sys_rst)
    !spread_en |=> freq_offset_khz == 8'sh00) else $error("offset while disabled");
  AST_DEV_BOUND: assert property (@(posedge core_clk) disable iff (sys_rst)
    freq_offset_khz <= DEV && freq_offset_khz >= -DEV) else $error("deviation exceeded");
  AST_PG_DIP: assert property (@(posedge core_clk) disable iff (sys_rst)
    !(buck1_ok && buck2_ok) |=> !power_good_reset_n) else $error("power good despite dip");
  AST_PG_SHORT: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(power_good_reset_n) && func_q[3:2] == 2'b00 |-> $past(bucks_ok, 10)) else $error("delay too short");
  AST_LDO_WR: assert property (@(posedge core_clk) disable iff (sys_rst)
    wr_ldo1 |=> reg1_voltage_code == $past(reg_req.wdata[4:0])) else $error("ldo write lost");

endmodule

// ---- include/prsl_pkg.sv ----
package prsl_pkg;

  // Register byte addresses on the serial register port.
  localparam logic [7:0] ADDR_RAMP = 8'h2B;  // Buck2 ramp rate.
  localparam logic [7:0] ADDR_FUNC = 8'h38;  // Buck function control.
  localparam logic [7:0] ADDR_LDO1 = 8'h39;  // LDO1 voltage control.

  // Writable bit masks; every other bit is reserved and holds its reset value, which is zero except ramp bit 5.
  localparam logic [7:0] MASK_RAMP = 8'h0F;  // Ramp code only; bits 7..4 keep their reset pattern.
  localparam logic [7:0] MASK_FUNC = 8'h1F;
  localparam logic [7:0] MASK_LDO1 = 8'h1F;

  // Reset values.
  localparam logic [7:0] RST_RAMP     = 8'h28;
  localparam logic [7:0] RST_FUNC_LOW = 8'h02;  // Slow modulation set, spreading off.
  localparam logic [7:0] RST_LDO1     = 8'h00;

  // Field positions in the function register.
  localparam int FUNC_SPREAD_BIT = 0;
  localparam int FUNC_SLOW_BIT   = 1;
  localparam int FUNC_DELAY_LSB  = 2;
  localparam int FUNC_BYPASS_BIT = 4;

  // Ramp codes.
  localparam logic [3:0] RAMP_INSTANT = 4'h0;
  localparam logic [3:0] RAMP_MAX     = 4'hA;

  // LDO code range.
  localparam logic [4:0] LDO_CODE_MAX = 5'h19;

  // Clock and spread-spectrum timing at a 100 MHz core clock.
  localparam int CLK_MHZ         = 100;
  localparam int FAST_MOD_KHZ    = 10;
  localparam int SLOW_MOD_KHZ    = 2;
  localparam int DEV_STEPS       = 100;  // Deviation of +/-100 kHz in 1 kHz steps.
  // Cycles per 1 kHz step: one period spans 4*DEV_STEPS steps.
  localparam int FAST_STEP_CYC   = (CLK_MHZ * 1000) / (FAST_MOD_KHZ * 4 * DEV_STEPS);
  localparam int SLOW_STEP_CYC   = (CLK_MHZ * 1000) / (SLOW_MOD_KHZ * 4 * DEV_STEPS);

  // Reset delay times.
  localparam int DLY0_US = 50;
  localparam int DLY1_MS = 50;
  localparam int DLY2_MS = 100;
  localparam int DLY3_MS = 200;

  // Register write/read request carried together.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } prsl_req_type;

  // Sweep direction state.
  typedef enum logic [0:0] {
    SWEEP_UP   = 1'b0,
    SWEEP_DOWN = 1'b1
  } prsl_sweep_type;

endpackage

// ---- testbench/prsl_host.sv ----
`timescale 1ns/100ps

// Host model: issues one-cycle register requests between falling edges.
module prsl_host (
  input  wire logic               core_clk,  // Core clock.
  output prsl_pkg::prsl_req_type  reg_req,   // Request to the registers.
  input  wire logic [7:0]         reg_rdata  // Registered read data.
);
  initial reg_req = '0;

  // Write one byte; the request stands for exactly one rising edge.
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge core_clk);
    reg_req = '0;
  endtask

  // Read one byte; data is taken a full cycle later, since it holds until the next read.
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge core_clk);
    reg_req = '0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask
endmodule

// ---- testbench/testbench.sv ----
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_mismatch++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end

module testbench;
  logic                   core_clk, sys_rst, buck1_ok, buck2_ok, supply_low;  // Clock, reset and monitors.
  logic [7:0]             func_strap, rd, reg_rdata;                          // Strap and read data.
  prsl_pkg::prsl_req_type reg_req;                                            // Host request.
  logic [3:0]             ramp_step_code;                                     // Effective ramp code.
  logic [4:0]             reg1_voltage_code;                                  // LDO1 code.
  logic signed [7:0]      freq_offset_khz;                                    // Sweep offset.
  logic                   ramp_instant, spread_en, power_good_reset_n, regulators_en;
  int                     n_mismatch = 0;                                     // Mismatches seen.
  int                     n_checks = 0;                                       // Comparisons made.
  // Rows of {written code, expected code, expected instant flag}.
  logic [8:0]             rows [5] = '{9'h001, 9'h022, 9'h154, 9'h174, 9'h1F4};

  prsl_regs #(.DLY0_CYC(10), .DLY1_CYC(20), .DLY2_CYC(40), .DLY3_CYC(80)) prsl_regs_i (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .func_strap(func_strap), .buck1_ok(buck1_ok), .buck2_ok(buck2_ok), .supply_low(supply_low),
    .ramp_step_code(ramp_step_code), .ramp_instant(ramp_instant), .spread_en(spread_en),
    .freq_offset_khz(freq_offset_khz), .power_good_reset_n(power_good_reset_n),
    .regulators_en(regulators_en), .reg1_voltage_code(reg1_voltage_code));
  prsl_host prsl_host_i (.core_clk(core_clk), .reg_req(reg_req), .reg_rdata(reg_rdata));

  // Free-running 100 MHz clock.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog: the tests need about 220 cycles, so this is ample.
  initial begin
    #100us;
    n_mismatch++;
    print_verdict();
  end

  // Main sequence: reset values, table of ramp codes, then the awkward cases.
  initial begin
    sys_rst = 1'b1; func_strap = 8'h14; buck1_ok = 1'b1; buck2_ok = 1'b1; supply_low = 1'b0;
    repeat (8) @(negedge core_clk);
    sys_rst = 1'b0;
    prsl_host_i.read_reg(prsl_pkg::ADDR_RAMP, rd); `CHK(rd, 8'h28)
    prsl_host_i.read_reg(prsl_pkg::ADDR_FUNC, rd); `CHK(rd, 8'h16)
    prsl_host_i.read_reg(prsl_pkg::ADDR_LDO1, rd); `CHK(rd, 8'h00)
    foreach (rows[i]) begin
      prsl_host_i.write_reg(prsl_pkg::ADDR_RAMP, {4'h0, rows[i][8:5]});
      @(negedge core_clk);
      `CHK({ramp_step_code, ramp_instant}, rows[i][4:0])
    end
    // Reserved top bit of the ramp register must not stick.
    prsl_host_i.write_reg(prsl_pkg::ADDR_RAMP, 8'hFF);
    prsl_host_i.read_reg(prsl_pkg::ADDR_RAMP, rd); `CHK(rd, 8'h2F)
    prsl_host_i.write_reg(prsl_pkg::ADDR_LDO1, 8'hF9);
    prsl_host_i.read_reg(prsl_pkg::ADDR_LDO1, rd); `CHK(rd, 8'h19)
    `CHK(reg1_voltage_code, 5'h19)
    prsl_host_i.read_reg(8'h3A, rd); `CHK(rd, 8'h00)
    // Low supply with the bypass set by the strap keeps regulators on.
    supply_low = 1'b1;
    @(negedge core_clk);
    `CHK(regulators_en, 1'b1)
    prsl_host_i.write_reg(prsl_pkg::ADDR_FUNC, 8'h01);
    @(negedge core_clk);
    `CHK(regulators_en, 1'b0)
    `CHK(spread_en, 1'b1)
    supply_low = 1'b0;
    // Fast sweep steps once per 25 cycles: still centred at edge 24, first step at edge 25.
    repeat (23) @(negedge core_clk);
    `CHK(freq_offset_khz, 8'sh00)
    @(negedge core_clk);
    `CHK(freq_offset_khz, 8'sh01)
    // A monitor dip drops the reset at once; it releases after ten cycles.
    buck1_ok = 1'b0;
    repeat (2) @(negedge core_clk);
    `CHK(power_good_reset_n, 1'b0)
    buck1_ok = 1'b1;
    repeat (5) @(negedge core_clk);
    `CHK(power_good_reset_n, 1'b0)
    repeat (10) @(negedge core_clk);
    `CHK(power_good_reset_n, 1'b1)
    // Park the sweep, then restart it in slow mode: one step per 125 cycles.
    prsl_host_i.write_reg(prsl_pkg::ADDR_FUNC, 8'h00);
    prsl_host_i.write_reg(prsl_pkg::ADDR_FUNC, 8'h03);
    repeat (124) @(negedge core_clk);
    `CHK(freq_offset_khz, 8'sh00)
    @(negedge core_clk);
    `CHK(freq_offset_khz, 8'sh01)
    prsl_host_i.write_reg(prsl_pkg::ADDR_FUNC, 8'h00);
    @(negedge core_clk);
    `CHK(spread_en, 1'b0)
    print_verdict();
  end
endmodule
